// [dv/cbcr_clk_model.sv]
// Behavioural model of the external jitter attenuator clock chip.
`timescale 1ns/1ps
`default_nettype none
module cbcr_clk_model (
	input  wire cbcr_pkg::cbcr_drive_t drive_i,
	output logic [1:0]                 qa_rate_o,
	output logic [1:0]                 qb_rate_o
);
	// ****************************************************************
	// Rate codes: 0 is 1x, 1 is 1.25x, 2 is 2.5x, 3 is stopped.
	// ****************************************************************
	logic [3:0] rates;
	always_comb begin
		case (drive_i.freq_select)
			3'h0: rates = 4'hA;
			3'h4: rates = 4'h2;
			3'h2: rates = 4'h6;
			3'h6: rates = 4'h9;
			3'h1: rates = 4'h8;
			3'h5: rates = 4'h1;
			3'h3: rates = 4'h4;
			3'h7: rates = 4'h5;
			default: rates = 4'hF;
		endcase
		qa_rate_o = rates[3:2];
		qb_rate_o = rates[1:0];
		// Reset wins over both disables, as the chip stops all outputs then.
		if (drive_i.attenuator_master_reset || drive_i.group_a_output_disable) begin
			qa_rate_o = 2'h3;
		end
		if (drive_i.attenuator_master_reset || drive_i.group_b_output_disable) begin
			qb_rate_o = 2'h3;
		end
	end
endmodule
`default_nettype wire

// [dv/cbcr_regs_tb.sv]
// Self-checking testbench of the clock board control register bank.
`timescale 1ns/1ps
`default_nettype none
module cbcr_regs_tb;
	logic                  clk = 1'b0;
	logic                  nrst = 1'b0;
	logic [9:0]            awaddr = '0, araddr = '0;
	logic [31:0]           wdata = '0;
	logic                  awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                  arvalid = 1'b0, rready = 1'b0;
	logic [3:0]            wstrb = 4'hF;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, qa, qb;
	logic [31:0]           rdata;
	cbcr_pkg::cbcr_drive_t drv;
	int                    miscompares = 0, tests_run = 0, cyc = 0;
	logic [7:0]            v;
	// Only codes that keep group A at 2.5x are used, so its frequency never moves.
	logic [2:0]            sel [3] = '{3'h0, 3'h6, 3'h1};
	logic [2:0]            ctl [3] = '{3'h7, 3'h2, 3'h1};
	logic [7:0]            gbv [5] = '{8'hFF, 8'h20, 8'h10, 8'h01, 8'hCE};
	// Group B rates for those codes: 2.5x, 1.25x and 1x.
	logic [1:0]            qbr [3] = '{2'h2, 2'h1, 2'h0};

	cbcr_regs dut_u (.sys_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .drive_o(drv));
	cbcr_clk_model chip_u (.drive_i(drv), .qa_rate_o(qa), .qb_rate_o(qb));

	// ****************************************************************
	// Bus tasks
	// ****************************************************************
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	// Handshakes are judged at the falling edge, where the ready lines are settled.
	task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] er);
		logic       ah, wh, bh;
		logic [1:0] r;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) bready <= 1'b0;
		end while (bh !== 1'b1);
		// One edge passes so that a following call never drives a ready line twice in a step.
		@(posedge clk);
		cmp({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [9:0] a, input logic [7:0] ed, input logic [1:0] er);
		logic        arh, rh;
		logic [1:0]  r;
		logic [31:0] dat;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			arh = arvalid & arready;
			rh = rvalid;
			r = rresp;
			dat = rdata;
			@(posedge clk);
			if (arh) arvalid <= 1'b0;
			if (rh) rready <= 1'b0;
		end while (rh !== 1'b1);
		@(posedge clk);
		cmp(dat, {24'h0, ed});
		cmp({30'h0, r}, {30'h0, er});
	endtask

	task automatic end_of_test();
		$display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Clock, watchdog and tests
	// ****************************************************************
	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(cbcr_pkg::JAC_ADDR, 8'h10, 2'h0);
		rd(cbcr_pkg::GBC_ADDR, 8'h00, 2'h0);
		cmp({23'h0, drv}, 32'h40);
		cmp({30'h0, qa}, 32'h2);
		cmp({30'h0, qb}, 32'h0);
		$display("Test reset values done");
		for (int i = 0; i < 5; i++) begin
			wr(cbcr_pkg::GBC_ADDR, gbv[i], 2'h0);
			v = gbv[i] & 8'h31;
			rd(cbcr_pkg::GBC_ADDR, v, 2'h0);
			cmp({23'h0, drv}, {29'h8, v[4], v[5], v[0]});
		end
		wstrb <= 4'h0;
		wr(cbcr_pkg::GBC_ADDR, 8'h31, 2'h0);
		wstrb <= 4'hF;
		rd(cbcr_pkg::GBC_ADDR, 8'h00, 2'h0);
		$display("Test board control done");
		for (int i = 0; i < 3; i++) begin
			v = {1'b1, sel[i], 1'b1, ctl[i]};
			wr(cbcr_pkg::JAC_ADDR, v, 2'h0);
			rd(cbcr_pkg::JAC_ADDR, v & 8'h77, 2'h0);
			cmp({23'h0, drv}, {23'h0, sel[i], ctl[i], 3'h0});
			cmp({30'h0, qa}, (ctl[i][2] | ctl[i][0]) ? 32'h3 : 32'h2);
			cmp({30'h0, qb}, (ctl[i][2] | ctl[i][1]) ? 32'h3 : {30'h0, qbr[i]});
		end
		$display("Test attenuator control done");
		wr(10'h04C, 8'hFF, 2'h2);
		rd(10'h04C, 8'h00, 2'h2);
		rd(cbcr_pkg::JAC_ADDR, 8'h11, 2'h0);
		$display("Test unmapped access done");
		wr(cbcr_pkg::GBC_ADDR, 8'h31, 2'h0);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(cbcr_pkg::JAC_ADDR, 8'h10, 2'h0);
		rd(cbcr_pkg::GBC_ADDR, 8'h00, 2'h0);
		cmp({23'h0, drv}, 32'h40);
		$display("Test reset in mid-run done");
		end_of_test();
	end
endmodule
`default_nettype wire

// [include/cbcr_pkg.sv]
// Package with register map, field layout and reset values of the clock board control registers.
`default_nettype none
package cbcr_pkg;

	// ****************************************************************
	// Register offsets are word indices; the byte address is four times the index.
	// ****************************************************************
	localparam logic [7:0] JAC_INDEX = 8'h12;
	localparam logic [7:0] GBC_INDEX = 8'h18;
	localparam logic [9:0] JAC_ADDR  = {JAC_INDEX, 2'b00};
	localparam logic [9:0] GBC_ADDR  = {GBC_INDEX, 2'b00};
	localparam int         ADDR_W    = 10;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int JAC_SEL_LSB  = 4;
	localparam int JAC_SEL_MSB  = 6;
	localparam int JAC_MR_BIT   = 2;
	localparam int JAC_OEB_BIT  = 1;
	localparam int JAC_OEA_BIT  = 0;
	localparam int GBC_RAM1_BIT = 5;
	localparam int GBC_RAM0_BIT = 4;
	localparam int GBC_LOC_BIT  = 0;

	// ****************************************************************
	// Reset values and writable masks
	// ****************************************************************
	localparam logic [7:0] JAC_RESET = 8'h10;
	localparam logic [7:0] GBC_RESET = 8'h00;
	localparam logic [7:0] JAC_WMASK = 8'h77;
	localparam logic [7:0] GBC_WMASK = 8'h31;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Drive group carried to the external clock and memory chips.
	typedef struct packed {
		logic [2:0] freq_select;
		logic       attenuator_master_reset;
		logic       group_b_output_disable;
		logic       group_a_output_disable;
		logic       first_ram_loop_disable;
		logic       second_ram_loop_disable;
		logic       local_clock_disable;
	} cbcr_drive_t;

endpackage

`default_nettype wire

// [logic/cbcr_regs.sv]
// Clock board control register bank with AXI4-Lite slave.
//
// Function
// - Bits 6:4 of attenuator control drive the clock chip frequency select.
// - Board control bit 5 disables second RAM loop, read/write, resets to 0.
// - Board control bit 4 disables first RAM loop, read/write, resets to 0.
// - Board control bit 0 disables local 250 MHz clock, resets to 0.
// - Board control bits 7, 6, 3, 2, 1 read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none

module cbcr_regs (
	input  wire logic                        sys_clk_i,
	input  wire logic                        nrst_i,
	input  wire logic [cbcr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input  wire logic                        s_axi_awvalid_i,
	output logic                             s_axi_awready_o,
	input  wire logic [31:0]                 s_axi_wdata_i,
	input  wire logic [3:0]                  s_axi_wstrb_i,
	input  wire logic                        s_axi_wvalid_i,
	output logic                             s_axi_wready_o,
	output logic [1:0]                       s_axi_bresp_o,
	output logic                             s_axi_bvalid_o,
	input  wire logic                        s_axi_bready_i,
	input  wire logic [cbcr_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input  wire logic                        s_axi_arvalid_i,
	output logic                             s_axi_arready_o,
	output logic [31:0]                      s_axi_rdata_o,
	output logic [1:0]                       s_axi_rresp_o,
	output logic                             s_axi_rvalid_o,
	input  wire logic                        s_axi_rready_i,
	output cbcr_pkg::cbcr_drive_t            drive_o
);

	// ****************************************************************
	// Write channel: address and data latched independently
	// ****************************************************************
	logic                        aw_hold_ff, nxt_aw_hold;
	logic                        w_hold_ff, nxt_w_hold;
	logic [cbcr_pkg::ADDR_W-1:0] awaddr_ff, nxt_awaddr;
	logic [7:0]                  wdata_ff, nxt_wdata;
	logic                        wstrb0_ff, nxt_wstrb0;
	logic                        bvalid_ff, nxt_bvalid;
	logic [1:0]                  bresp_ff, nxt_bresp;
	logic [7:0]                  jac_ff, nxt_jac;
	logic [7:0]                  gbc_ff, nxt_gbc;

	assign s_axi_awready_o = !aw_hold_ff && !bvalid_ff;
	assign s_axi_wready_o  = !w_hold_ff && !bvalid_ff;

	always_comb begin
		nxt_aw_hold = aw_hold_ff;
		nxt_w_hold  = w_hold_ff;
		nxt_awaddr  = awaddr_ff;
		nxt_wdata   = wdata_ff;
		nxt_wstrb0  = wstrb0_ff;
		nxt_bvalid  = bvalid_ff;
		nxt_bresp   = bresp_ff;
		nxt_jac     = jac_ff;
		nxt_gbc     = gbc_ff;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			nxt_aw_hold = 1'b1;
			nxt_awaddr  = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			nxt_w_hold = 1'b1;
			nxt_wdata  = s_axi_wdata_i[7:0];
			nxt_wstrb0 = s_axi_wstrb_i[0];
		end
		// Commit once both halves are held; the response is raised on the same edge as the register update.
		if (aw_hold_ff && w_hold_ff) begin
			nxt_aw_hold = 1'b0;
			nxt_w_hold  = 1'b0;
			nxt_bvalid  = 1'b1;
			nxt_bresp   = cbcr_pkg::RESP_OKAY;
			if (awaddr_ff == cbcr_pkg::JAC_ADDR) begin
				if (wstrb0_ff) begin
					nxt_jac = wdata_ff & cbcr_pkg::JAC_WMASK;
				end
			end else if (awaddr_ff == cbcr_pkg::GBC_ADDR) begin
				if (wstrb0_ff) begin
					nxt_gbc = wdata_ff & cbcr_pkg::GBC_WMASK;
				end
			end else begin
				nxt_bresp = cbcr_pkg::RESP_SLVERR;
			end
		end
		if (bvalid_ff && s_axi_bready_i) begin
			nxt_bvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff  <= 1'b0;
			awaddr_ff  <= '0;
			wdata_ff   <= 8'h00;
			wstrb0_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= cbcr_pkg::RESP_OKAY;
			jac_ff     <= cbcr_pkg::JAC_RESET;
			gbc_ff     <= cbcr_pkg::GBC_RESET;
		end else begin
			aw_hold_ff <= nxt_aw_hold;
			w_hold_ff  <= nxt_w_hold;
			awaddr_ff  <= nxt_awaddr;
			wdata_ff   <= nxt_wdata;
			wstrb0_ff  <= nxt_wstrb0;
			bvalid_ff  <= nxt_bvalid;
			bresp_ff   <= nxt_bresp;
			jac_ff     <= nxt_jac;
			gbc_ff     <= nxt_gbc;
		end
	end

	assign s_axi_bvalid_o = bvalid_ff;
	assign s_axi_bresp_o  = bresp_ff;

	// ****************************************************************
	// Read channel
	// ****************************************************************
	logic        rvalid_ff, nxt_rvalid;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0]  rresp_ff, nxt_rresp;

	assign s_axi_arready_o = !rvalid_ff;

	always_comb begin
		nxt_rvalid = rvalid_ff;
		nxt_rdata  = rdata_ff;
		nxt_rresp  = rresp_ff;
		if (s_axi_arvalid_i && s_axi_arready_o) begin
			nxt_rvalid = 1'b1;
			nxt_rresp  = cbcr_pkg::RESP_OKAY;
			if (s_axi_araddr_i == cbcr_pkg::JAC_ADDR) begin
				nxt_rdata = {24'h000000, jac_ff};
			end else if (s_axi_araddr_i == cbcr_pkg::GBC_ADDR) begin
				nxt_rdata = {24'h000000, gbc_ff};
			end else begin
				nxt_rdata = 32'h00000000;
				nxt_rresp = cbcr_pkg::RESP_SLVERR;
			end
		end else if (rvalid_ff && s_axi_rready_i) begin
			nxt_rvalid = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!nrst_i) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= cbcr_pkg::RESP_OKAY;
		end else begin
			rvalid_ff <= nxt_rvalid;
			rdata_ff  <= nxt_rdata;
			rresp_ff  <= nxt_rresp;
		end
	end

	assign s_axi_rvalid_o = rvalid_ff;
	assign s_axi_rdata_o  = rdata_ff;
	assign s_axi_rresp_o  = rresp_ff;

	// ****************************************************************
	// Pin drive
	// ****************************************************************
	// Group A frequency is not guarded in hardware; software keeps it steady.
	always_comb begin
		drive_o.freq_select             = jac_ff[cbcr_pkg::JAC_SEL_MSB:cbcr_pkg::JAC_SEL_LSB];
		drive_o.attenuator_master_reset = jac_ff[cbcr_pkg::JAC_MR_BIT];
		drive_o.group_b_output_disable  = jac_ff[cbcr_pkg::JAC_OEB_BIT];
		drive_o.group_a_output_disable  = jac_ff[cbcr_pkg::JAC_OEA_BIT];
		drive_o.second_ram_loop_disable = gbc_ff[cbcr_pkg::GBC_RAM1_BIT];
		drive_o.first_ram_loop_disable  = gbc_ff[cbcr_pkg::GBC_RAM0_BIT];
		drive_o.local_clock_disable     = gbc_ff[cbcr_pkg::GBC_LOC_BIT];
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_gbc_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(gbc_ff & ~cbcr_pkg::GBC_WMASK) == 8'h00)
		else $error("Reserved board control bits not zero.");

	chk_gbc_write_ram1: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff && wstrb0_ff && awaddr_ff == cbcr_pkg::GBC_ADDR)
		|=> drive_o.second_ram_loop_disable == $past(wdata_ff[5]))
		else $error("Second RAM loop disable did not follow write.");

	chk_gbc_write_ram0: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff && wstrb0_ff && awaddr_ff == cbcr_pkg::GBC_ADDR)
		|=> drive_o.first_ram_loop_disable == $past(wdata_ff[4]))
		else $error("First RAM loop disable did not follow write.");

	chk_gbc_write_loc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff && wstrb0_ff && awaddr_ff == cbcr_pkg::GBC_ADDR)
		|=> drive_o.local_clock_disable == $past(wdata_ff[0]))
		else $error("Local clock disable did not follow write.");

	chk_jac_write_sel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff && wstrb0_ff && awaddr_ff == cbcr_pkg::JAC_ADDR)
		|=> drive_o.freq_select == $past(wdata_ff[6:4]))
		else $error("Frequency select did not follow write.");

	chk_jac_write_ctl: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff && wstrb0_ff && awaddr_ff == cbcr_pkg::JAC_ADDR)
		|=> {drive_o.attenuator_master_reset, drive_o.group_b_output_disable,
			drive_o.group_a_output_disable} == $past(wdata_ff[2:0]))
		else $error("Attenuator control bits did not follow write.");

	chk_reset_values: assert property (@(posedge sys_clk_i)
		!nrst_i |=> (gbc_ff == 8'h00 && jac_ff[2:0] == 3'h0))
		else $error("Control bits not zero after reset.");

	chk_read_gbc: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == cbcr_pkg::GBC_ADDR)
		|=> s_axi_rvalid_o && s_axi_rdata_o[7:6] == 2'h0 && s_axi_rdata_o[3:1] == 3'h0)
		else $error("Board control read shows reserved bits set.");

	chk_write_resp: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
		(aw_hold_ff && w_hold_ff) |=> s_axi_bvalid_o)
		else $error("Write response not raised after commit.");

endmodule

`default_nettype wire
